// *** hdl/dmaa_defs.vh ***
`ifndef DMAA_DEFS_VH
`define DMAA_DEFS_VH

// Command codes on CMD_TYPE
`define DMAA_CMD_SINGLE_READ  3'h0
`define DMAA_CMD_SINGLE_WRITE 3'h1
`define DMAA_CMD_SEQ_READ     3'h2
`define DMAA_CMD_SEQ_WRITE    3'h3
`define DMAA_CMD_REPEAT_READ  3'h4

// Access size codes on CMD_SIZE
`define DMAA_SIZE_BYTE 2'h0
`define DMAA_SIZE_WORD 2'h1
`define DMAA_SIZE_LONG 2'h2

// Filler returned by failed reads, one per byte
`define DMAA_FILLER_BYTE 8'hEE
`define DMAA_FILLER_LONG 32'hEEEEEEEE

// Reset values
`define DMAA_ADDR_RESET 24'h000000
`define DMAA_DATA_RESET 32'h00000000

`endif

// *** hdl/dmaa_top.v ***
`timescale 1ns/10ps
`include "dmaa_defs.vh"

module dmaa_top (
   // Clock and reset
   input  wire        CLOCK,
   input  wire        RESET_N,
   // Command from the link decoder
   input  wire        CMD_VALID,
   output reg         CMD_READY,
   input  wire [2:0]  CMD_TYPE,
   input  wire [1:0]  CMD_SIZE,
   input  wire [23:0] CMD_ADDR,
   input  wire [31:0] CMD_WDATA,
   // Internal memory bus
   output reg         MEM_REQ,
   output reg         MEM_WRITE,
   output reg  [23:0] MEM_ADDR,
   output reg  [3:0]  MEM_LANES,
   output reg  [31:0] MEM_WDATA,
   input  wire        MEM_ACK,
   input  wire        MEM_ERR,
   input  wire [31:0] MEM_RDATA,
   // Read data toward the link serializer
   output reg         RSP_VALID,
   input  wire        RSP_READY,
   output reg  [31:0] RSP_DATA,
   output reg  [1:0]  RSP_SIZE,
   // Status flags
   input  wire        FLAG_CLEAR,
   output reg         ILLEGAL_ACCESS_FLAG,
   output reg         READ_INVALID_FLAG
);

   // Bytes covered by a size code
   function [2:0] size_bytes;
      input [1:0] size;
      begin
         case (size)
            `DMAA_SIZE_BYTE: size_bytes = 3'h1;
            `DMAA_SIZE_WORD: size_bytes = 3'h2;
            default:         size_bytes = 3'h4;
         endcase
      end
   endfunction

   // Field offset after realignment
   function [1:0] eff_offset;
      input [1:0] size;
      input [1:0] off;
      begin
         if (size == `DMAA_SIZE_LONG)
            eff_offset = 2'h0;
         else if (size == `DMAA_SIZE_WORD && off == 2'h3)
            eff_offset = 2'h2;
         else
            eff_offset = off;
      end
   endfunction

   // Lane mask, bit 3 is lane 00 (most significant byte)
   function [3:0] lane_mask;
      input [1:0] size;
      input [1:0] off;
      begin
         case (size)
            `DMAA_SIZE_BYTE: lane_mask = 4'h8 >> off;
            `DMAA_SIZE_WORD: lane_mask = 4'hC >> off;
            default:         lane_mask = 4'hF;
         endcase
      end
   endfunction

   // Bit shift between lane position and right-justified data
   function [4:0] lane_shift;
      input [1:0] size;
      input [1:0] off;
      reg   [2:0] gap;
      begin
         gap = 3'h4 - {1'b0, off} - size_bytes(size);
         lane_shift = {gap[1:0], 3'h0};
      end
   endfunction

   // Mask that keeps only bytes of the access size
   function [31:0] size_keep;
      input [1:0] size;
      begin
         case (size)
            `DMAA_SIZE_BYTE: size_keep = 32'h000000FF;
            `DMAA_SIZE_WORD: size_keep = 32'h0000FFFF;
            default:         size_keep = 32'hFFFFFFFF;
         endcase
      end
   endfunction

   // Controller states
   localparam [1:0] st_idle = 2'h0;
   localparam [1:0] st_mem  = 2'h1;
   localparam [1:0] st_push = 2'h2;

   reg  [1:0]  state;
   reg  [23:0] last_addr;
   reg  [1:0]  last_size;
   reg  [23:0] rep_base;
   reg         seq_rd_ok;
   reg         seq_wr_ok;
   reg         rep_ok;
   reg         cur_read;
   reg  [1:0]  cur_size;
   reg  [4:0]  cur_shift;
   reg  [31:0] res_data;
   reg  [1:0]  res_size;

   // Two-entry response buffer
   reg         full1;
   reg  [31:0] data1;
   reg  [1:0]  size1;
   wire        buf_in_ready = ~full1;
   wire        buf_push     = (state == st_push) & buf_in_ready;
   wire        buf_pop      = RSP_VALID & RSP_READY;

   // Command decode
   wire        take      = CMD_VALID & CMD_READY & (state == st_idle);
   wire        is_sread  = (CMD_TYPE == `DMAA_CMD_SINGLE_READ);
   wire        is_swrite = (CMD_TYPE == `DMAA_CMD_SINGLE_WRITE);
   wire        is_qread  = (CMD_TYPE == `DMAA_CMD_SEQ_READ);
   wire        is_qwrite = (CMD_TYPE == `DMAA_CMD_SEQ_WRITE);
   wire        is_rep    = (CMD_TYPE == `DMAA_CMD_REPEAT_READ);
   wire        known     = (is_sread | is_swrite | is_qread | is_qwrite | is_rep) &
                           (CMD_SIZE != 2'h3);
   wire        is_read   = is_sread | is_qread | is_rep;
   wire        cmd_ok    = is_sread | is_swrite | (is_qread & seq_rd_ok) |
                           (is_qwrite & seq_wr_ok) | (is_rep & rep_ok);

   // Increment base: longword uses zeroed low bits, word keeps original
   wire [23:0] inc_base  = (last_size == `DMAA_SIZE_LONG) ?
                           {last_addr[23:2], 2'h0} : last_addr;
   wire [23:0] seq_addr  = inc_base + {21'h000000, size_bytes(last_size)};
   reg  [23:0] raw_addr;
   always @* begin
      if (is_sread | is_swrite)
         raw_addr = CMD_ADDR;
      else if (is_rep)
         raw_addr = rep_base;
      else
         raw_addr = seq_addr;
   end
   wire [1:0]  off       = eff_offset(CMD_SIZE, raw_addr[1:0]);
   wire [4:0]  shamt     = lane_shift(CMD_SIZE, off);

   // Read data extracted from covered lanes only
   wire [31:0] rd_extract = (MEM_RDATA >> cur_shift) & size_keep(cur_size);
   wire [31:0] filler_cur = `DMAA_FILLER_LONG & size_keep(cur_size);
   wire [31:0] filler_cmd = `DMAA_FILLER_LONG & size_keep(CMD_SIZE);
   wire        mem_done   = (state == st_mem) & MEM_ACK;

   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         state     <= st_idle;
         CMD_READY <= 1'b0;
         MEM_REQ   <= 1'b0;
         MEM_WRITE <= 1'b0;
         MEM_ADDR  <= `DMAA_ADDR_RESET;
         MEM_LANES <= 4'h0;
         MEM_WDATA <= `DMAA_DATA_RESET;
         last_addr <= `DMAA_ADDR_RESET;
         last_size <= `DMAA_SIZE_BYTE;
         rep_base  <= `DMAA_ADDR_RESET;
         seq_rd_ok <= 1'b0;
         seq_wr_ok <= 1'b0;
         rep_ok    <= 1'b0;
         cur_read  <= 1'b0;
         cur_size  <= `DMAA_SIZE_BYTE;
         cur_shift <= 5'h00;
         res_data  <= `DMAA_DATA_RESET;
         res_size  <= `DMAA_SIZE_BYTE;
      end else begin
         case (state)
            st_idle: begin
               CMD_READY <= 1'b1;
               if (take) begin
                  if (!known) begin
                     seq_rd_ok <= 1'b0;
                     seq_wr_ok <= 1'b0;
                     rep_ok    <= 1'b0;
                  end else if (!cmd_ok) begin
                     if (is_read) begin
                        CMD_READY <= 1'b0;
                        res_data  <= filler_cmd;
                        res_size  <= CMD_SIZE;
                        state     <= st_push;
                     end
                  end else begin
                     CMD_READY <= 1'b0;
                     MEM_REQ   <= 1'b1;
                     MEM_WRITE <= ~is_read;
                     MEM_ADDR  <= {raw_addr[23:2], off};
                     MEM_LANES <= lane_mask(CMD_SIZE, off);
                     MEM_WDATA <= (CMD_WDATA & size_keep(CMD_SIZE)) << shamt;
                     cur_read  <= is_read;
                     cur_size  <= CMD_SIZE;
                     cur_shift <= shamt;
                     if (!is_rep) begin
                        last_addr <= raw_addr;
                        last_size <= CMD_SIZE;
                     end
                     if (is_sread) begin
                        rep_base <= CMD_ADDR;
                        rep_ok   <= 1'b1;
                     end
                     if (is_sread | is_swrite) begin
                        seq_rd_ok <= 1'b1;
                        seq_wr_ok <= 1'b1;
                     end
                     state <= st_mem;
                  end
               end
            end
            st_mem: begin
               if (MEM_ACK) begin
                  MEM_REQ <= 1'b0;
                  if (MEM_ERR) begin
                     seq_wr_ok <= 1'b0;
                     rep_ok    <= 1'b0;
                  end
                  if (cur_read) begin
                     res_data <= MEM_ERR ? filler_cur : rd_extract;
                     res_size <= cur_size;
                     state    <= st_push;
                  end else begin
                     CMD_READY <= 1'b1;
                     state     <= st_idle;
                  end
               end
            end
            st_push: begin
               if (buf_in_ready) begin
                  CMD_READY <= 1'b1;
                  state     <= st_idle;
               end
            end
            default: begin
               CMD_READY <= 1'b0;
               state     <= st_idle;
            end
         endcase
      end
   end

   // Status flags; a new event wins over a same-cycle clear
   wire set_illegal = mem_done & MEM_ERR;
   wire set_read_invalid_flag   = take & known & ~cmd_ok & is_read;
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         ILLEGAL_ACCESS_FLAG <= 1'b0;
         READ_INVALID_FLAG   <= 1'b0;
      end else begin
         if (set_illegal)
            ILLEGAL_ACCESS_FLAG <= 1'b1;
         else if (FLAG_CLEAR)
            ILLEGAL_ACCESS_FLAG <= 1'b0;
         if (set_read_invalid_flag)
            READ_INVALID_FLAG <= 1'b1;
         else if (FLAG_CLEAR)
            READ_INVALID_FLAG <= 1'b0;
      end
   end

   // Response buffer: head is the output register, second entry absorbs a stall
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         RSP_VALID <= 1'b0;
         RSP_DATA  <= `DMAA_DATA_RESET;
         RSP_SIZE  <= `DMAA_SIZE_BYTE;
         full1     <= 1'b0;
         data1     <= `DMAA_DATA_RESET;
         size1     <= `DMAA_SIZE_BYTE;
      end else begin
         if (full1) begin
            if (buf_pop) begin
               RSP_DATA <= data1;
               RSP_SIZE <= size1;
               full1    <= 1'b0;
            end
         end else if (buf_push) begin
            if (!RSP_VALID || buf_pop) begin
               RSP_VALID <= 1'b1;
               RSP_DATA  <= res_data;
               RSP_SIZE  <= res_size;
            end else begin
               full1 <= 1'b1;
               data1 <= res_data;
               size1 <= res_size;
            end
         end else if (buf_pop) begin
            RSP_VALID <= 1'b0;
         end
      end
   end

endmodule

// *** verification/dmaa_checker.sv ***
`timescale 1ns/10ps
module dmaa_checker (
   // Clock and reset
   input wire        CLOCK,
   input wire        RESET_N,
   // Watched ports
   input wire        CMD_READY,
   input wire        MEM_REQ,
   input wire        MEM_WRITE,
   input wire [23:0] MEM_ADDR,
   input wire [3:0]  MEM_LANES,
   input wire [31:0] MEM_WDATA,
   input wire        MEM_ACK,
   input wire        MEM_ERR,
   input wire        RSP_VALID,
   input wire        RSP_READY,
   input wire [31:0] RSP_DATA,
   input wire [1:0]  RSP_SIZE,
   input wire        ILLEGAL_ACCESS_FLAG
);
   wire [31:0] mask = {{8{MEM_LANES[3]}}, {8{MEM_LANES[2]}}, {8{MEM_LANES[1]}}, {8{MEM_LANES[0]}}};
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   long_align_a: assert property (MEM_REQ && MEM_LANES == 4'hF |-> MEM_ADDR[1:0] == 2'h0)
      else $error("longword access not aligned");
   lane_map_a: assert property (MEM_REQ |-> MEM_LANES == 4'hF || MEM_LANES == 4'h8 >> MEM_ADDR[1:0]
      || MEM_LANES == 4'hC >> MEM_ADDR[1:0] && MEM_ADDR[1:0] != 2'h3) else $error("bad lane set");
   wdata_lanes_a: assert property (MEM_REQ && MEM_WRITE |-> (MEM_WDATA & ~mask) == 32'h0)
      else $error("write data outside lanes");
   rsp_width_a: assert property (RSP_VALID |-> RSP_SIZE == 2'h2 || RSP_DATA >> (RSP_SIZE == 2'h0 ? 8 : 16) == 0)
      else $error("response wider than size");
   req_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_LANES))
      else $error("request changed before ack");
   req_drop_a: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ) else $error("request held after ack");
   illegal_flag_a: assert property (MEM_REQ && MEM_ACK && MEM_ERR |=> ILLEGAL_ACCESS_FLAG)
      else $error("illegal flag not set");
   rsp_hold_a: assert property (RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP_DATA) && $stable(RSP_SIZE))
      else $error("response changed while stalled");
   busy_ready_a: assert property (MEM_REQ |-> !CMD_READY) else $error("command ready while busy");
endmodule
bind dmaa_top dmaa_checker i_dmaa_checker (.CLOCK(CLOCK), .RESET_N(RESET_N), .CMD_READY(CMD_READY),
   .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .MEM_LANES(MEM_LANES), .MEM_WDATA(MEM_WDATA),
   .MEM_ACK(MEM_ACK), .MEM_ERR(MEM_ERR), .RSP_VALID(RSP_VALID), .RSP_READY(RSP_READY), .RSP_DATA(RSP_DATA),
   .RSP_SIZE(RSP_SIZE), .ILLEGAL_ACCESS_FLAG(ILLEGAL_ACCESS_FLAG));

// *** verification/dmaa_mem_model.sv ***
`timescale 1ns/10ps
module dmaa_mem_model (
   // Clock and reset
   input  wire        clock,
   input  wire        reset_n,
   // Memory bus
   input  wire        mem_req,
   input  wire [23:0] mem_addr,
   input  wire [1:0]  delay,
   output reg         mem_ack,
   output reg         mem_err,
   output reg  [31:0] mem_rdata
);
   reg  [1:0] wait_cnt;
   wire       busy = mem_req && !mem_ack;
   wire       take = busy && wait_cnt == 2'h0;
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         mem_rdata <= 32'h00000000;
         wait_cnt <= 2'h0;
      end else begin
         mem_ack <= take;
         mem_err <= take && mem_addr[23:20] == 4'hF;
         mem_rdata <= take ? {mem_addr[23:2], 2'h0, 8'h5A} : ~mem_rdata;
         wait_cnt <= busy && wait_cnt != 2'h0 ? wait_cnt - 2'h1 : delay;
      end
   end
endmodule

// *** verification/dmaa_top_test.sv ***
`timescale 1ns/10ps
`include "dmaa_defs.vh"
module dmaa_top_test;
   reg         CLOCK = 1'b0, RESET_N = 1'b0, CMD_VALID = 1'b0, RSP_READY = 1'b0, FLAG_CLEAR = 1'b0;
   reg  [2:0]  CMD_TYPE = 3'h0;
   reg  [1:0]  CMD_SIZE = 2'h0, delay = 2'h0, lsz = 2'h0, j;
   reg  [23:0] CMD_ADDR = 24'h0, last = 24'h0, base = 24'h0;
   reg  [31:0] CMD_WDATA = 32'h0;
   reg  [15:0] lfsr = 16'h001B;
   reg         sr = 0, sw = 0, rp = 0, e_ill = 0, e_inv = 0, hold = 0;
   reg  [60:0] aq[$];
   reg  [33:0] rq[$];
   integer     mismatches = 0, checks_done = 0, i;
   wire        CMD_READY, MEM_REQ, MEM_WRITE, MEM_ACK, MEM_ERR, RSP_VALID, ILLEGAL_ACCESS_FLAG, READ_INVALID_FLAG;
   wire [23:0] MEM_ADDR;
   wire [3:0]  MEM_LANES;
   wire [31:0] MEM_WDATA, MEM_RDATA, RSP_DATA;
   wire [1:0]  RSP_SIZE;
   always #2.5 CLOCK = ~CLOCK;
   dmaa_top i_dmaa_top (.CLOCK(CLOCK), .RESET_N(RESET_N), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
      .CMD_TYPE(CMD_TYPE), .CMD_SIZE(CMD_SIZE), .CMD_ADDR(CMD_ADDR), .CMD_WDATA(CMD_WDATA), .MEM_REQ(MEM_REQ),
      .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .MEM_LANES(MEM_LANES), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
      .MEM_ERR(MEM_ERR), .MEM_RDATA(MEM_RDATA), .RSP_VALID(RSP_VALID), .RSP_READY(RSP_READY), .RSP_DATA(RSP_DATA),
      .RSP_SIZE(RSP_SIZE), .FLAG_CLEAR(FLAG_CLEAR), .ILLEGAL_ACCESS_FLAG(ILLEGAL_ACCESS_FLAG),
      .READ_INVALID_FLAG(READ_INVALID_FLAG));
   dmaa_mem_model i_dmaa_mem_model (.clock(CLOCK), .reset_n(RESET_N), .mem_req(MEM_REQ), .mem_addr(MEM_ADDR),
      .delay(delay), .mem_ack(MEM_ACK), .mem_err(MEM_ERR), .mem_rdata(MEM_RDATA));
   function [15:0] step(input [15:0] v);
      step = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task chk(input string what, input [63:0] seen, input [63:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task do_cmd(input [2:0] t, input [1:0] s, input [23:0] a, input [31:0] w);
      reg [23:0] r, ea;
      reg [1:0]  sh;
      reg [3:0]  ln;
      reg [31:0] m;
      reg        ok, bad;
      integer    n;
      begin
         r = t == 3'h4 ? base : (t == 3'h2 || t == 3'h3) ? last + (24'h1 << lsz) : a;
         ea = s == 2'h2 ? r & 24'hFFFFFC : (s == 2'h1 && r[1:0] == 2'h3) ? r - 24'h1 : r;
         sh = s == 2'h2 ? 2'h0 : s == 2'h1 ? 2'h2 - ea[1:0] : 2'h3 - ea[1:0];
         m = s == 2'h0 ? 32'hFF : s == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF;
         ln = {m[24], m[16], m[8], m[0]} << sh;
         ok = t < 3'h2 || t == 3'h2 && sr || t == 3'h3 && sw || t == 3'h4 && rp;
         bad = ea[23:20] == 4'hF;
         if (t > 3'h4 || s == 2'h3) {sr, sw, rp} = 3'h0;
         else if (ok) begin
            aq.push_back({t[0], ea, ln, (w & m) << {sh, 3'h0}});
            if (!t[0]) rq.push_back({s, bad ? `DMAA_FILLER_LONG & m : ({ea[23:2], 2'h0, 8'h5A} >> {sh, 3'h0}) & m});
            if (t < 3'h4) {last, lsz} = {s == 2'h2 ? ea : r, s};
            if (t < 3'h2) {sr, sw} = 2'h3;
            if (t == 3'h0) {rp, base} = {1'b1, a};
            if (bad) {e_ill, sw, rp} = 3'h4;
         end else if (t != 3'h3) begin
            rq.push_back({s, `DMAA_FILLER_LONG & m});
            e_inv = 1'b1;
         end
         CMD_VALID <= 1'b1;
         {CMD_TYPE, CMD_SIZE, CMD_ADDR, CMD_WDATA} <= {t, s, a, w};
         n = 0;
         do begin
            @(posedge CLOCK);
            n = n + 1;
         end while (CMD_READY !== 1'b1 && n < 200);
         chk("command taken", CMD_READY, 1'b1);
         CMD_VALID <= 1'b0;
         repeat (3) @(posedge CLOCK);
         for (n = 0; CMD_READY !== 1'b1 && n < 60; n = n + 1) @(posedge CLOCK);
         @(posedge CLOCK);
         chk("illegal flag", ILLEGAL_ACCESS_FLAG, e_ill);
         chk("invalid flag", READ_INVALID_FLAG, e_inv);
      end
   endtask
   task clear_flags;
      begin
         FLAG_CLEAR <= 1'b1;
         @(posedge CLOCK);
         FLAG_CLEAR <= 1'b0;
         {e_ill, e_inv} = 2'h0;
         @(posedge CLOCK);
      end
   endtask
   always @(posedge CLOCK) begin
      if (MEM_REQ && MEM_ACK) begin
         chk("mem access", {MEM_WRITE, MEM_ADDR, MEM_LANES}, aq[0][60:32]);
         if (MEM_WRITE) chk("mem wdata", MEM_WDATA, aq[0][31:0]);
         aq.pop_front();
      end
      if (RSP_VALID && RSP_READY) chk("response", {RSP_SIZE, RSP_DATA}, rq.pop_front());
      // Stall every other cycle at most while hold is clear (hold stalls every cycle), so a held buffer drains
      RSP_READY <= !hold && (lfsr[4:3] != 2'h0 || !RSP_READY);
      delay <= lfsr[9:8];
   end
   initial begin
      #100000;
      mismatches = mismatches + 1;
      give_verdict;
   end
   initial begin
      repeat (4) @(posedge CLOCK);
      RESET_N <= 1'b1;
      chk("reset", {CMD_READY, MEM_REQ, RSP_VALID, ILLEGAL_ACCESS_FLAG, READ_INVALID_FLAG}, 5'h0);
      repeat (2) @(posedge CLOCK);
      do_cmd(3'h2, 2'h0, 24'h0, 32'h0);
      do_cmd(3'h0, 2'h2, 24'h004003, 32'h0);
      for (i = 6; i >= 0; i = i - 1) do_cmd(3'h2, 2'(14'h2515 >> (2 * i)), 24'h0, 32'h0);
      for (i = 0; i < 6; i = i + 1) begin
         do_cmd(3'h0, 2'(12'h502 >> (2 * i)), 24'(144'h004003004001004003004002004000004003 >> (24 * i)), 32'h0);
         for (j = 0; j < 3; j = j + 1) do_cmd(3'h4, j, 24'h0, 32'h0);
      end
      do_cmd(3'h0, 2'h0, 24'hF00010, 32'h0);
      do_cmd(3'h2, 2'h1, 24'h0, 32'h0);
      do_cmd(3'h3, 2'h0, 24'h0, 32'h11);
      do_cmd(3'h4, 2'h0, 24'h0, 32'h0);
      do_cmd(3'h2, 2'h0, 24'h0, 32'h0);
      do_cmd(3'h1, 2'h1, 24'h004007, 32'hABCD);
      do_cmd(3'h3, 2'h2, 24'h0, 32'h12345678);
      do_cmd(3'h6, 2'h0, 24'h0, 32'h0);
      do_cmd(3'h2, 2'h0, 24'h0, 32'h0);
      clear_flags;
      hold = 1'b1;
      repeat (3) do_cmd(3'h0, 2'h2, 24'h004100, 32'h0);
      chk("buffer full", {CMD_READY, RSP_VALID}, 2'h1);
      hold = 1'b0;
      for (i = 0; i < 150; i = i + 1) begin
         lfsr = step(lfsr);
         do_cmd(lfsr[2:0] > 3'h4 && lfsr[5] ? 3'h2 : lfsr[2:0], lfsr[7:6] == 2'h3 && lfsr[8] ? 2'h1 : lfsr[7:6],
            {lfsr[10:8] == 3'h7 ? 8'hF0 : 8'h00, 4'h4, lfsr[11:0]}, {lfsr, ~lfsr});
         if (lfsr[15:13] == 3'h0) clear_flags;
      end
      repeat (50) @(posedge CLOCK);
      chk("left over", rq.size() + aq.size(), 0);
      give_verdict;
   end
endmodule
